// file: pts_chk_assertions.sv
`timescale 1ns/1ps
`include "pts_defs.vh"

module pts_chk
(
  // clock and reset
  input wire                clk,
  input wire                arst_n,
  // down counters
  input wire                qtr_mode,
  input wire                os_run,
  input wire [`PTS_W-1:0]   os_reload,
  input wire [`PTS_W-1:0]   os_count,
  input wire                os_irq,
  input wire [`PTS_W-1:0]   app_count,
  input wire                app_irq,
  // watchdog and time stamp
  input wire [`PTS_W-1:0]   wd_load,
  input wire                wd_load_wr,
  input wire [`PTS_W-1:0]   wd_count,
  input wire                wd_expired,
  input wire                ts_reload_wr,
  input wire [`PTS_W-1:0]   ts_compare,
  input wire [`PTS_W-1:0]   ts_count,
  input wire                ts_match_irq,
  input wire                ts_roll_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  AST_TS_RELOAD: assert property (ts_reload_wr |-> ##2 ts_count == `PTS_TS_RELOAD)
    else $error("time stamp reload value wrong");
  AST_TS_MATCH: assert property (ts_match_irq |=> ts_count == $past(ts_compare))
    else $error("match pulse without equal count");
  AST_OS_IRQ: assert property (os_irq |-> $past(os_count) == 0)
    else $error("os pulse not after zero");
  AST_OS_RELOAD: assert property (os_irq |-> os_count == $past(os_reload, 2))
    else $error("os counter did not reload");
  AST_APP_IRQ: assert property (app_irq |-> $past(app_count) == 0)
    else $error("app pulse not after zero");
  AST_WD_LOAD: assert property (wd_load_wr |-> ##2 wd_count == $past(wd_load, 2))
    else $error("watchdog load wrong");
  AST_WD_CLEAR: assert property (wd_load_wr && wd_load != 0 |=> !wd_expired)
    else $error("watchdog flag not cleared");
  AST_WD_STOP: assert property (wd_expired && !wd_load_wr |=> wd_expired && wd_count == 0)
    else $error("watchdog left zero");
  AST_STOP_HOLD: assert property ((qtr_mode && !os_run) [*3] |-> $stable(os_count))
    else $error("stopped counter moved");
  AST_TS_ROLL: assert property (ts_roll_irq |=> ts_count == 0)
    else $error("rollover pulse without wrap to zero");
  cover property (os_irq);
  cover property (ts_match_irq);
  cover property (wd_expired);
endmodule // pts_chk

bind pts_timer_subsys pts_chk u_pts_chk (.*);

// file: pts_defs.vh
`ifndef PTS_DEFS_VH
`define PTS_DEFS_VH

// counter width
`define PTS_W            32
// prescaler divide field width
`define PTS_PRE_W        8
// time-stamp reload value
`define PTS_TS_RELOAD    32'h0000_0001
// three-fourths-rate phase counter: one skipped bus clock out of four
`define PTS_QTR_W        2
`define PTS_QTR_SKIP     2'h3
`define PTS_QTR_RST      2'h0
`define PTS_QTR_STEP     2'h1
// count step, last watchdog count and time-stamp maximum
`define PTS_STEP         32'h0000_0001
`define PTS_WD_LAST      32'h0000_0001
`define PTS_TS_MAX       32'hffff_ffff
// reset values
`define PTS_RST_COUNT    32'h0000_0000
`define PTS_RST_PRE      8'h00

`endif

// file: pts_down_counter.v
`timescale 1ns/1ps
`include "pts_defs.vh"

// ----------------------------------------------------------------
// reloading down counter with optional prescaler
// ----------------------------------------------------------------
module pts_down_counter
(
  // clock and reset
  input  wire                    clk,
  input  wire                    arst_n,
  // control
  input  wire                    run,
  input  wire                    tick,
  input  wire                    use_pre,
  input  wire [`PTS_PRE_W-1:0]   pre_div,
  input  wire [`PTS_W-1:0]       reload,
  // state
  output reg  [`PTS_W-1:0]       count_reg,
  output reg                     zero_reg
);

  reg [`PTS_PRE_W-1:0] pre_reg;
  reg                  run_d_reg;
  wire                 pre_hit = !use_pre || (pre_reg == pre_div);
  wire                 adv     = run && tick && pre_hit;

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_reg <= `PTS_RST_COUNT;
      pre_reg   <= `PTS_RST_PRE;
      zero_reg  <= 1'b0;
      run_d_reg <= 1'b0;
    end
    else
    begin
      run_d_reg <= run;
      zero_reg  <= 1'b0;
      if (run && !run_d_reg)
      begin
        // start always from the programmed value, never the held one
        count_reg <= reload;
        pre_reg   <= `PTS_RST_PRE;
      end
      else if (run && tick)
      begin
        pre_reg <= pre_hit ? `PTS_RST_PRE : pre_reg + 8'h01;
        if (adv)
        begin
          if (count_reg == `PTS_RST_COUNT)
          begin
            count_reg <= reload;
            zero_reg  <= 1'b1;
          end
          else
            count_reg <= count_reg - 32'h0000_0001;
        end
      end
    end
  end

endmodule // pts_down_counter

// file: pts_timer_subsys.v
`timescale 1ns/1ps
`include "pts_defs.vh"

// What this block does
// - two independent down timers: os tick and application
// - also a countdown watchdog and an up-counting time-stamp counter
// - time-stamp reload loads one, not zero
// - prescaler on all timers except the watchdog
// - three-fourths-rate mode advances counters on three of four clocks
// - time-stamp compare value raises interrupt on equality
// - time-stamp keeps counting after a compare match
// - per-timer run control can stop a timer in three-fourths mode
// - restart after stop reloads, except the watchdog, which pauses and continues
module pts_timer_subsys
(
  // clock and reset
  input  wire                  clk,
  input  wire                  arst_n,
  // common configuration
  input  wire                  qtr_mode,
  // os tick down counter
  input  wire                  os_run,
  input  wire                  os_pre_en,
  input  wire [`PTS_PRE_W-1:0] os_pre_div,
  input  wire [`PTS_W-1:0]     os_reload,
  output reg  [`PTS_W-1:0]     os_count,
  output reg                   os_irq,
  // application down counter
  input  wire                  app_run,
  input  wire                  app_pre_en,
  input  wire [`PTS_PRE_W-1:0] app_pre_div,
  input  wire [`PTS_W-1:0]     app_reload,
  output reg  [`PTS_W-1:0]     app_count,
  output reg                   app_irq,
  // watchdog
  input  wire                  wd_run,
  input  wire [`PTS_W-1:0]     wd_load,
  input  wire                  wd_load_wr,
  output reg  [`PTS_W-1:0]     wd_count,
  output reg                   wd_expired,
  // time stamp
  input  wire                  ts_run,
  input  wire                  ts_pre_en,
  input  wire [`PTS_PRE_W-1:0] ts_pre_div,
  input  wire                  ts_reload_wr,
  input  wire [`PTS_W-1:0]     ts_compare,
  output reg  [`PTS_W-1:0]     ts_count,
  output reg                   ts_match_irq,
  output reg                   ts_roll_irq
);

  // ----------------------------------------------------------------
  // three-fourths-rate tick
  // ----------------------------------------------------------------
  // phase counter free-runs; the tick drops out once every four clocks
  reg  [`PTS_QTR_W-1:0] qtr_reg;
  wire                  tick = !qtr_mode || (qtr_reg != `PTS_QTR_SKIP);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      qtr_reg <= `PTS_QTR_RST;
    else
      qtr_reg <= qtr_reg + `PTS_QTR_STEP;
  end

  // ----------------------------------------------------------------
  // run controls
  // ----------------------------------------------------------------
  // for the os, app and time-stamp timers stop exists only in three-fourths mode; at full rate they free-run
  // a rising go reloads its timer, so a stopped timer never resumes
  wire os_go  = os_run  || !qtr_mode;
  wire app_go = app_run || !qtr_mode;
  wire ts_go  = ts_run  || !qtr_mode;

  // ----------------------------------------------------------------
  // general-purpose down timers
  // ----------------------------------------------------------------
  // both timers share the phase tick so their rates stay in step
  // zero flags are one-clock pulses from the zero step
  wire [`PTS_W-1:0] os_cnt_w;
  wire [`PTS_W-1:0] app_cnt_w;
  wire              os_zero_w;
  wire              app_zero_w;

  pts_down_counter u_os_tick_down_counter
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (os_go),
    .tick      (tick),
    .use_pre   (os_pre_en),
    .pre_div   (os_pre_div),
    .reload    (os_reload),
    .count_reg (os_cnt_w),
    .zero_reg  (os_zero_w)
  );

  pts_down_counter u_application_down_counter
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .run       (app_go),
    .tick      (tick),
    .use_pre   (app_pre_en),
    .pre_div   (app_pre_div),
    .reload    (app_reload),
    .count_reg (app_cnt_w),
    .zero_reg  (app_zero_w)
  );

  // ----------------------------------------------------------------
  // watchdog, no prescaler
  // ----------------------------------------------------------------
  // the count parks at zero and the expiry flag holds until the next load
  reg  [`PTS_W-1:0] wd_reg;
  wire              wd_step = wd_run && tick && (wd_reg != `PTS_RST_COUNT);
  wire              wd_last = (wd_reg == `PTS_WD_LAST);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wd_reg     <= `PTS_RST_COUNT;
      wd_expired <= 1'b0;
    end
    // a load outranks the last step, so a reload never leaves a stale expiry
    else if (wd_load_wr)
    begin
      wd_reg     <= wd_load;
      wd_expired <= 1'b0;
    end
    else if (wd_step)
    begin
      wd_reg <= wd_reg - `PTS_STEP;
      if (wd_last)
        wd_expired <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // time-stamp up counter
  // ----------------------------------------------------------------
  // a reload write or a rising go both restart the count at one
  reg  [`PTS_W-1:0]     ts_reg;
  reg  [`PTS_PRE_W-1:0] ts_pre_reg;
  reg                   ts_go_d_reg;
  wire                  ts_pre_hit = !ts_pre_en || (ts_pre_reg == ts_pre_div);
  wire                  ts_restart = ts_reload_wr || (ts_go && !ts_go_d_reg);
  wire                  ts_tick    = ts_go && tick;
  wire [`PTS_W-1:0]     ts_next    = ts_reg + `PTS_STEP;
  // both events are judged on the advance itself, so a pulse marks its own step
  wire                  ts_hit_cmp = (ts_next == ts_compare);
  wire                  ts_at_max  = (ts_reg == `PTS_TS_MAX);

  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ts_reg       <= `PTS_RST_COUNT;
      ts_pre_reg   <= `PTS_RST_PRE;
      ts_go_d_reg  <= 1'b0;
      ts_match_irq <= 1'b0;
      ts_roll_irq  <= 1'b0;
    end
    else
    begin
      ts_go_d_reg  <= ts_go;
      ts_match_irq <= 1'b0;
      ts_roll_irq  <= 1'b0;
      if (ts_restart)
      begin
        // prescaler restarts with the count, so the first step takes a full divide
        ts_reg     <= `PTS_TS_RELOAD;
        ts_pre_reg <= `PTS_RST_PRE;
      end
      else if (ts_tick)
      begin
        ts_pre_reg <= ts_pre_hit ? `PTS_RST_PRE : ts_pre_reg + 8'h01;
        if (ts_pre_hit)
        begin
          ts_reg <= ts_next;
          if (ts_hit_cmp)
            ts_match_irq <= 1'b1;
          if (ts_at_max)
            ts_roll_irq <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  // counts lag their counters by one clock
  // irq pulses follow the zero step by one clock
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      os_count  <= `PTS_RST_COUNT;
      app_count <= `PTS_RST_COUNT;
      wd_count  <= `PTS_RST_COUNT;
      ts_count  <= `PTS_RST_COUNT;
      os_irq    <= 1'b0;
      app_irq   <= 1'b0;
    end
    else
    begin
      os_count  <= os_cnt_w;
      app_count <= app_cnt_w;
      wd_count  <= wd_reg;
      ts_count  <= ts_reg;
      os_irq    <= os_zero_w;
      app_irq   <= app_zero_w;
    end
  end

endmodule // pts_timer_subsys

// file: testbench.sv
`timescale 1ns/1ps
`include "pts_defs.vh"

module testbench;
  typedef struct {logic [31:0] r; logic p; logic [7:0] d; logic q; int e;} pts_row_t;
  reg                 clk, arst_n, qtr_mode, os_run, os_pre_en, app_run, app_pre_en;
  reg                 wd_run, wd_load_wr, ts_run, ts_pre_en, ts_reload_wr;
  reg  [7:0]          os_pre_div, app_pre_div, ts_pre_div;
  reg  [`PTS_W-1:0]   os_reload, app_reload, wd_load, ts_compare, held;
  wire [`PTS_W-1:0]   os_count, app_count, wd_count, ts_count;
  wire                os_irq, app_irq, wd_expired, ts_match_irq, ts_roll_irq;
  int                 n_fail, check_count, n, k;
  pts_row_t           rows [6];

  pts_timer_subsys u_pts_timer_subsys (.*);

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // counts falling edges up to the next pulse of the chosen timer
  task gap(input logic a, output int c);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end while ((a ? app_irq : os_irq) !== 1'b1 && c < 3000);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (10000) @(posedge clk);
    n_fail++;
    end_of_test;
  end

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial
  begin
    {arst_n, qtr_mode, os_pre_en, app_pre_en, wd_load_wr, ts_pre_en, ts_reload_wr} = 0;
    {os_run, app_run, wd_run, ts_run} = 4'hf;
    {os_pre_div, app_pre_div, ts_pre_div} = 0;
    {os_reload, app_reload, wd_load} = 0;
    ts_compare = 32'h40;
    rows = '{'{32'h2, 0, 8'h0, 0, 3}, '{32'h5, 0, 8'h0, 0, 6}, '{32'h3, 1, 8'h1, 0, 8},
             '{32'h1, 1, 8'h3, 0, 8}, '{32'h5, 0, 8'h0, 1, 8}, '{32'h2, 0, 8'h0, 1, 4}};
    repeat (10) @(posedge clk);
    chk("os_count in reset", 32'h0, os_count);
    arst_n <= 1;
    @(posedge clk) ts_reload_wr <= 1;
    @(posedge clk) ts_reload_wr <= 0;
    repeat (2) @(negedge clk);
    chk("ts_count after reload", `PTS_TS_RELOAD, ts_count);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (ts_match_irq !== 1'b1 && k < 3000);
    chk("match delay", 32'd62, k);
    repeat (2) @(negedge clk);
    chk("ts_count after match", 32'h41, ts_count);
    foreach (rows[i])
    begin
      @(posedge clk);
      os_reload <= rows[i].r;
      app_reload <= rows[i].r;
      {os_pre_en, app_pre_en} <= {2{rows[i].p}};
      {os_pre_div, app_pre_div} <= {2{rows[i].d}};
      qtr_mode <= rows[i].q;
      repeat (4) gap(0, n);
      chk("os period", rows[i].e, n);
      repeat (3) gap(1, n);
      chk("app period", rows[i].e, n);
    end
    @(posedge clk) os_reload <= 32'h64;
    repeat (3) gap(0, n);
    repeat (20) @(posedge clk);
    os_run <= 0;
    repeat (4) @(negedge clk);
    held = os_count;
    repeat (6) @(negedge clk);
    chk("stopped count", held, os_count);
    @(posedge clk) os_run <= 1;
    repeat (3) @(negedge clk);
    chk("count after restart", 32'h64, os_count);
    @(posedge clk)
    begin
      qtr_mode <= 0;
      wd_load <= 32'h5;
      wd_load_wr <= 1;
    end
    @(posedge clk) wd_load_wr <= 0;
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end while (wd_expired !== 1'b1 && k < 100);
    chk("watchdog expiry", 32'd6, k);
    repeat (3) @(negedge clk);
    chk("watchdog held", 32'h0, wd_count);
    @(posedge clk) wd_load_wr <= 1;
    @(posedge clk) wd_load_wr <= 0;
    @(negedge clk);
    chk("watchdog flag cleared", 32'h0, wd_expired);
    @(posedge clk)
    begin
      qtr_mode <= 1;
      ts_run <= 0;
    end
    repeat (4) @(negedge clk);
    held = ts_count;
    repeat (4) @(negedge clk);
    chk("ts stopped", held, ts_count);
    @(posedge clk)
    begin
      qtr_mode <= 0;
      ts_run <= 1;
      ts_pre_en <= 1;
      ts_pre_div <= 8'h1;
    end
    repeat (3) @(negedge clk);
    chk("ts after restart", `PTS_TS_RELOAD, ts_count);
    repeat (8) @(negedge clk);
    chk("ts prescaled", 32'h5, ts_count);
    chk("ts rollover idle", 32'h0, ts_roll_irq);
    end_of_test;
  end
endmodule // testbench
